//--- src/urcdr_pkg.sv
// Shared constants and types of the receive clock and data recovery block.
// Assumes one system clock domain; the sample tick is derived inside the block.
package urcdr_pkg;

    // Samples per bit in each speed mode
    localparam logic [4:0] SPB_NORMAL = 5'h10;
    localparam logic [4:0] SPB_DOUBLE = 5'h08;

    // First of the three centre voting samples in each speed mode
    localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;

    // Offsets of the second and third voting samples from the first
    localparam logic [4:0] VOTE_OFS_MID = 5'h01;
    localparam logic [4:0] VOTE_OFS_LAST = 5'h02;

    // Data plus parity bits per frame
    localparam int DATA_W = 10;
    localparam int BITS_W = 4;
    localparam logic [3:0] BITS_MIN = 4'h5;
    localparam logic [3:0] BITS_MAX = 4'hA;

    // Reset values
    localparam logic LINE_IDLE = 1'b1;
    localparam logic [4:0] CNT_RESET = 5'h00;
    localparam logic [3:0] BIT_IDX_RESET = 4'h0;
    localparam logic [9:0] DATA_RESET = 10'h000;

    // Default width of the baud divisor
    localparam int DIV_W_DEFAULT = 12;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } urcdr_state_t;

endpackage

//--- src/urcdr_sync.sv
// Two-stage synchroniser for the asynchronous serial line.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/100ps
`default_nettype none
module urcdr_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Line
    input wire logic async_in,
    output logic sync_out
);

    typedef struct packed {
        logic meta;
        logic stable;
    } urcdr_sync_t;

    urcdr_sync_t r;
    urcdr_sync_t next_r;

    // First stage is read only by the second stage
    always_comb begin
        next_r = r;
        next_r.meta = async_in;
        next_r.stable = r.meta;
    end

    // Reset to idle level so no false start edge appears after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            r.meta <= urcdr_pkg::LINE_IDLE;
            r.stable <= urcdr_pkg::LINE_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.stable;

endmodule
`default_nettype wire

//--- src/urcdr_top.sv
// Receive clock and data recovery for an asynchronous serial port.
// Assumes a remote transmitter on rx_line and configuration from same-clock logic.
`timescale 1ns/100ps
`default_nettype none
module urcdr_top #(
    parameter int DIV_W = urcdr_pkg::DIV_W_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial line from the remote transmitter
    input wire logic rx_line,
    // Configuration
    input wire logic [DIV_W-1:0] baud_divisor,
    input wire logic double_speed_sel,
    input wire logic [3:0] frame_bits,
    // Received frame
    output logic frame_valid,
    output logic [9:0] frame_data,
    output logic framing_error_flag,
    output logic break_seen,
    // Status
    output logic start_seen,
    output logic noise_reject,
    output logic busy
);

    typedef struct packed {
        urcdr_pkg::urcdr_state_t state;
        logic [DIV_W-1:0] div_cnt;
        logic tick;
        logic sample;
        logic [4:0] cnt;
        logic vote_a;
        logic vote_b;
        logic [3:0] bit_idx;
        logic [3:0] nbits;
        logic ds;
        logic [9:0] shift;
        logic out_valid;
        logic [9:0] out_data;
        logic out_ferr;
        logic out_break;
        logic out_start;
        logic out_noise;
        logic out_busy;
    } urcdr_state_rec_t;

    urcdr_state_rec_t r;
    urcdr_state_rec_t next_r;
    logic line_s;

    // Line is asynchronous; nothing below looks at it before two flops
    urcdr_sync u_sync (
        .clk(clk),
        .rst(rst),
        .async_in(rx_line),
        .sync_out(line_s)
    );

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic [4:0] spb_of(input logic ds);
        spb_of = ds ? urcdr_pkg::SPB_DOUBLE : urcdr_pkg::SPB_NORMAL;
    endfunction

    function automatic logic [4:0] vote_first_of(input logic ds);
        vote_first_of = ds ? urcdr_pkg::VOTE_FIRST_DOUBLE : urcdr_pkg::VOTE_FIRST_NORMAL;
    endfunction

    // Out-of-range lengths are clamped rather than hanging the machine
    function automatic logic [3:0] clamp_bits(input logic [3:0] b);
        if (b < urcdr_pkg::BITS_MIN) begin
            clamp_bits = urcdr_pkg::BITS_MIN;
        end else if (b > urcdr_pkg::BITS_MAX) begin
            clamp_bits = urcdr_pkg::BITS_MAX;
        end else begin
            clamp_bits = b;
        end
    endfunction

    always_comb begin
        logic [4:0] k;
        logic [4:0] vf;
        logic [4:0] spb;
        logic voted;
        logic is_a;
        logic is_b;
        logic is_c;
        k = r.cnt + 5'h01;
        vf = vote_first_of(r.ds);
        spb = spb_of(r.ds);
        is_a = (k == vf);
        is_b = (k == vf + urcdr_pkg::VOTE_OFS_MID);
        is_c = (k == vf + urcdr_pkg::VOTE_OFS_LAST);
        voted = maj3(r.vote_a, r.vote_b, line_s);

        next_r = r;
        next_r.out_valid = 1'b0;
        next_r.out_start = 1'b0;
        next_r.out_noise = 1'b0;

        // Sample tick from the divisor: period is divisor plus one clocks
        if (r.div_cnt == '0) begin
            next_r.div_cnt = baud_divisor;
            next_r.tick = 1'b1;
        end else begin
            next_r.div_cnt = r.div_cnt - {{(DIV_W-1){1'b0}}, 1'b1};
            next_r.tick = 1'b0;
        end

        if (r.tick) begin
            next_r.sample = line_s;
            if (is_a) begin
                next_r.vote_a = line_s;
            end
            if (is_b) begin
                next_r.vote_b = line_s;
            end
            case (r.state)
                urcdr_pkg::ST_IDLE: begin
                    // High then low sample: that low sample is sample one
                    if (r.sample && !line_s) begin
                        next_r.state = urcdr_pkg::ST_START;
                        next_r.cnt = 5'h01;
                        next_r.ds = double_speed_sel;
                        next_r.nbits = clamp_bits(frame_bits);
                        next_r.shift = urcdr_pkg::DATA_RESET;
                        next_r.bit_idx = urcdr_pkg::BIT_IDX_RESET;
                        next_r.out_start = 1'b1;
                    end
                end
                urcdr_pkg::ST_START: begin
                    next_r.cnt = k;
                    if (is_c && voted) begin
                        next_r.state = urcdr_pkg::ST_IDLE;
                        next_r.cnt = urcdr_pkg::CNT_RESET;
                        next_r.out_noise = 1'b1;
                    end else if (k == spb) begin
                        // Counter restarts after this start bit; only the start edge realigns it, so drift accumulates until the frame ends
                        next_r.state = urcdr_pkg::ST_DATA;
                        next_r.cnt = urcdr_pkg::CNT_RESET;
                    end
                end
                urcdr_pkg::ST_DATA: begin
                    next_r.cnt = k;
                    if (is_c) begin
                        next_r.shift[r.bit_idx] = voted;
                    end
                    if (k == spb) begin
                        next_r.cnt = urcdr_pkg::CNT_RESET;
                        if (r.bit_idx == r.nbits - 4'h1) begin
                            next_r.state = urcdr_pkg::ST_STOP;
                        end else begin
                            next_r.bit_idx = r.bit_idx + 4'h1;
                        end
                    end
                end
                urcdr_pkg::ST_STOP: begin
                    next_r.cnt = k;
                    if (is_c) begin
                        // Only the first stop bit is looked at; back to idle at once
                        next_r.state = urcdr_pkg::ST_IDLE;
                        next_r.cnt = urcdr_pkg::CNT_RESET;
                        next_r.out_valid = 1'b1;
                        next_r.out_data = r.shift;
                        next_r.out_ferr = !voted;
                        next_r.out_break = !voted && (r.shift == urcdr_pkg::DATA_RESET);
                    end
                end
                default: begin
                    next_r.state = urcdr_pkg::ST_IDLE;
                    next_r.cnt = urcdr_pkg::CNT_RESET;
                end
            endcase
        end
        next_r.out_busy = (next_r.state != urcdr_pkg::ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r.state <= urcdr_pkg::ST_IDLE;
            r.div_cnt <= '0;
            r.tick <= 1'b0;
            r.sample <= urcdr_pkg::LINE_IDLE;
            r.cnt <= urcdr_pkg::CNT_RESET;
            r.vote_a <= 1'b0;
            r.vote_b <= 1'b0;
            r.bit_idx <= urcdr_pkg::BIT_IDX_RESET;
            r.nbits <= urcdr_pkg::BITS_MIN;
            r.ds <= 1'b0;
            r.shift <= urcdr_pkg::DATA_RESET;
            r.out_valid <= 1'b0;
            r.out_data <= urcdr_pkg::DATA_RESET;
            r.out_ferr <= 1'b0;
            r.out_break <= 1'b0;
            r.out_start <= 1'b0;
            r.out_noise <= 1'b0;
            r.out_busy <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign frame_valid = r.out_valid;
    assign frame_data = r.out_data;
    assign framing_error_flag = r.out_ferr;
    assign break_seen = r.out_break;
    assign start_seen = r.out_start;
    assign noise_reject = r.out_noise;
    assign busy = r.out_busy;

endmodule
`default_nettype wire

//--- bench/urcdr_tx.sv
// Remote transmitter model on the receive line.
// Assumes tasks are entered just after a falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module urcdr_tx (
    // Clock
    input wire logic clk,
    // Serial line, idle high
    output logic line
);
    initial line = 1'b1;
    task automatic hold(input logic v, input int clks);
        line = v;
        repeat (clks) @(negedge clk);
    endtask
    // Bit time is a whole number of ticks, so no rate error
    task automatic send(input logic [9:0] d, input logic [3:0] n, input logic stop,
            input int bc, input int sc);
        hold(1'b0, bc);
        for (int i = 0; i < int'(n); i++) begin
            hold(d[i], bc);
        end
        hold(stop, sc);
        // Only a low stop needs releasing; a frame right behind must see one write
        if (!stop) begin
            line = 1'b1;
        end
    endtask
    task automatic glitch(input int clks);
        hold(1'b0, clks);
        line = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- bench/urcdr_properties.sv
// Port checks of the recovery block.
// Assumes one clock and a synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module urcdr_properties #(
    parameter int DIV_W = urcdr_pkg::DIV_W_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Line and setup
    input wire logic rx_line,
    input wire logic [DIV_W-1:0] baud_divisor,
    input wire logic double_speed_sel,
    input wire logic [3:0] frame_bits,
    // Results
    input wire logic frame_valid,
    input wire logic [9:0] frame_data,
    input wire logic framing_error_flag,
    input wire logic break_seen,
    input wire logic start_seen,
    input wire logic noise_reject,
    input wire logic busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_start_pulse: assert property (start_seen |=> !start_seen) else $error("long start");
    a_start_busy: assert property (start_seen |-> busy[*4]) else $error("busy short");
    a_valid_pulse: assert property (frame_valid |=> !frame_valid) else $error("long valid");
    a_valid_idle: assert property (frame_valid |-> !busy && $past(busy)) else $error("idle");
    a_data_hold: assert property (!frame_valid |-> $stable(frame_data)) else $error("data");
    a_flag_hold: assert property (!frame_valid |-> $stable(framing_error_flag)
        && $stable(break_seen)) else $error("flag moved");
    a_break_flag: assert property (break_seen |-> framing_error_flag
        && frame_data == 10'h000) else $error("break");
    a_noise_idle: assert property (noise_reject |-> !busy ##1 !noise_reject) else $error("noise");
    c_good: cover property (frame_valid && !framing_error_flag);
    c_bad: cover property (frame_valid && framing_error_flag);
    c_noise: cover property (noise_reject);
endmodule
bind urcdr_top urcdr_properties #(.DIV_W(DIV_W)) u_props (.clk(clk), .rst(rst),
    .rx_line(rx_line), .baud_divisor(baud_divisor), .double_speed_sel(double_speed_sel),
    .frame_bits(frame_bits), .frame_valid(frame_valid), .frame_data(frame_data),
    .framing_error_flag(framing_error_flag), .break_seen(break_seen),
    .start_seen(start_seen), .noise_reject(noise_reject), .busy(busy));
`default_nettype wire

//--- bench/urcdr_top_tb.sv
// Self-checking bench of the recovery block.
// Assumes the transmitter model drives the line.
`timescale 1ns/100ps
`default_nettype none
module urcdr_top_tb;
    logic clk, rst, rx, sel, fv, ferr, brk, nr, st, bsy, g_ferr, g_brk;
    logic [11:0] div;
    logic [3:0] fbits;
    logic [9:0] data, g_data;
    int num_errors = 0, n_compared = 0, cyc = 0, n_fr = 0, n_nr = 0, n_st = 0;
    urcdr_tx tx (.clk(clk), .line(rx));
    urcdr_top #(.DIV_W(12)) DUT (.clk(clk), .rst(rst), .rx_line(rx), .baud_divisor(div),
        .double_speed_sel(sel), .frame_bits(fbits), .frame_valid(fv), .frame_data(data),
        .framing_error_flag(ferr), .break_seen(brk), .start_seen(st), .noise_reject(nr),
        .busy(bsy));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fv === 1'b1) begin
            n_fr <= n_fr + 1;
            g_data <= data;
            g_ferr <= ferr;
            g_brk <= brk;
        end
        if (nr === 1'b1) n_nr <= n_nr + 1;
        if (st === 1'b1) n_st <= n_st + 1;
        if (cyc == 30000) begin
            num_errors++;
            finish_test;
        end
    end
    task automatic chk(input string s, input logic [9:0] e, input logic [9:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic frame(input logic ds, input logic [3:0] n, input logic [9:0] d, input logic sb);
        int bc, f0, s0;
        logic [9:0] m;
        bc = (int'(div) + 1) * (ds ? 8 : 16);
        m = (10'h001 << n) - 10'h001;
        sel = ds;
        fbits = n;
        f0 = n_fr;
        s0 = n_st;
        tx.send(d, n, sb, bc, bc);
        repeat (bc) @(negedge clk);
        chk("count", 10'(f0 + 1), 10'(n_fr));
        chk("data", d & m, g_data);
        chk("ferr", {9'h000, !sb}, {9'h000, g_ferr});
        chk("break", {9'h000, !sb && (d & m) == 10'h000}, {9'h000, g_brk});
        chk("starts", 10'(s0 + 1), 10'(n_st));
        chk("busy", 10'h000, {9'h000, bsy});
    endtask
    task automatic t_formats;
        for (int m = 0; m < 2; m++) begin
            frame(m[0], 4'h5, 10'h3B6, 1'b1);
            frame(m[0], 4'h8, 10'h0C5, 1'b1);
            frame(m[0], 4'hA, 10'h2D3, 1'b1);
        end
    endtask
    task automatic t_errors;
        frame(1'b0, 4'h8, 10'h000, 1'b0);
        frame(1'b1, 4'h7, 10'h055, 1'b0);
    endtask
    task automatic t_noise;
        int f0, q0, s0;
        for (int m = 0; m < 2; m++) begin
            sel = m[0];
            f0 = n_fr;
            q0 = n_nr;
            s0 = n_st;
            tx.glitch((int'(div) + 1) * 2);
            repeat (40) @(negedge clk);
            chk("noise", 10'(q0 + 1), 10'(n_nr));
            chk("noframe", 10'(f0), 10'(n_fr));
            chk("nstart", 10'(s0 + 1), 10'(n_st));
        end
    endtask
    task automatic t_back_to_back;
        int f0;
        div = 12'h000;
        sel = 1'b0;
        fbits = 4'h8;
        repeat (4) @(negedge clk);
        f0 = n_fr;
        // Stop cut to ten samples: next start on the sample after the votes
        tx.send(10'h0A5, 4'h8, 1'b1, 16, 10);
        tx.send(10'h05A, 4'h8, 1'b1, 16, 16);
        repeat (16) @(negedge clk);
        chk("b2b_count", 10'(f0 + 2), 10'(n_fr));
        chk("b2b_data", 10'h05A, g_data);
    endtask
    task automatic finish_test;
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        div = 12'h001;
        sel = 1'b0;
        fbits = 4'h8;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        t_formats;
        t_errors;
        t_noise;
        t_back_to_back;
        finish_test;
    end
endmodule
`default_nettype wire
